// ===== hdl/spd_host_end.sv
// Host end: APB command port, status read-and-clear and DMA memory forwarding.
module spd_host_end (
  input wire logic CLOCK_IN,
  input wire logic RST_N_IN,
  spd_link_if.hst LINK,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  output logic IRQ_OUT,
  output logic MEM_REQ_OUT,
  output logic MEM_WE_OUT,
  output logic [15:0] MEM_ADDR_OUT,
  output logic [15:0] MEM_WDATA_OUT,
  input wire logic MEM_ACK_IN,
  input wire logic [15:0] MEM_RDATA_IN
);
  logic ack_reg;
  logic [15:0] cmd_reg;
  logic take;

  // Every transfer answers one cycle into its access phase.
  assign take = PSEL_IN & PENABLE_IN & ~ack_reg;

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ack_reg <= 1'b0;
      cmd_reg <= 16'h0000;
      PRDATA_OUT <= 32'h0000_0000;
      PSLVERR_OUT <= 1'b0;
      LINK.doc_pulse <= 1'b0;
      LINK.status_read_clear_instruction_pulse <= 1'b0;
      IRQ_OUT <= 1'b0;
    end else begin
      ack_reg <= take;
      LINK.doc_pulse <= 1'b0;
      LINK.status_read_clear_instruction_pulse <= 1'b0;
      IRQ_OUT <= LINK.irq;
      if (take) begin
        PRDATA_OUT <= 32'h0000_0000;
        PSLVERR_OUT <= 1'b0;
        case (PADDR_IN)
          spd_pkg::REG_CMD: begin
            if (PWRITE_IN) begin
              cmd_reg <= PWDATA_IN[15:0];
              LINK.doc_pulse <= 1'b1;
            end else begin
              PRDATA_OUT <= {16'h0000, cmd_reg};
            end
          end
          spd_pkg::REG_IRQ: PRDATA_OUT <= {31'h0000_0000, LINK.irq};
          spd_pkg::REG_STATUS: begin
            // Reading returns the status and clears its pending bits in one operation.
            if (!PWRITE_IN) begin
              PRDATA_OUT <= {16'h0000, LINK.status_word};
              LINK.status_read_clear_instruction_pulse <= 1'b1;
            end
          end
          default: PSLVERR_OUT <= 1'b1;
        endcase
      end
    end
  end

  // The doc data is taken from the command register one cycle after the write.
  assign LINK.doc_data = cmd_reg;
  assign PREADY_OUT = ack_reg;
  assign MEM_REQ_OUT = LINK.dma_req;
  assign MEM_WE_OUT = LINK.dma_we;
  assign MEM_ADDR_OUT = LINK.dma_addr;
  assign MEM_WDATA_OUT = LINK.dma_wdata;
  assign LINK.dma_ack = MEM_ACK_IN;
  assign LINK.dma_rdata = MEM_RDATA_IN;
endmodule

// ===== hdl/spd_link_if.sv
// Link between the scanner and the host I/O bus end.
interface spd_link_if (
  input wire logic clk,
  input wire logic rst_n
);
  logic doc_pulse;
  logic [15:0] doc_data;
  logic status_read_clear_instruction_pulse;
  logic [15:0] status_word;
  logic irq;
  logic dma_req;
  logic dma_we;
  logic [15:0] dma_addr;
  logic [15:0] dma_wdata;
  logic dma_ack;
  logic [15:0] dma_rdata;
  modport dev (
    input clk, rst_n, doc_pulse, doc_data, status_read_clear_instruction_pulse, dma_ack, dma_rdata,
    output status_word, irq, dma_req, dma_we, dma_addr, dma_wdata
  );
  modport hst (
    input clk, rst_n, status_word, irq, dma_req, dma_we, dma_addr, dma_wdata,
    output doc_pulse, doc_data, status_read_clear_instruction_pulse, dma_ack, dma_rdata
  );
endinterface

// ===== hdl/spd_pkg.sv
// Shared constants for the serial port DMA scanner and its host end.
package spd_pkg;
  localparam int WORD_W = 16;
  localparam int NPORT = 128;
  localparam int PORT_W = 7;
  // Default control block base: 36000 octal.
  localparam logic [15:0] BASE_DEFAULT = 16'h3c00;
  // Software base is given in units of 400 octal words.
  localparam int BASE_ALIGN = 8;
  // Control block word indexes.
  localparam logic [2:0] W_RX_CTL = 3'h0;
  localparam logic [2:0] W_TX_CTL = 3'h1;
  localparam logic [2:0] W_RX_PTR = 3'h4;
  localparam logic [2:0] W_TX_PTR = 3'h5;
  localparam logic [2:0] W_RX_END = 3'h6;
  localparam logic [2:0] W_TX_END = 3'h7;
  // Block size jumpers: 40, 20 or 10 octal words, as a shift of the port number.
  localparam logic [1:0] SIZE_SEL_20 = 2'h1;
  localparam logic [1:0] SIZE_SEL_10 = 2'h2;
  localparam logic [3:0] SHIFT_40 = 4'h5;
  localparam logic [3:0] SHIFT_20 = 4'h4;
  localparam logic [3:0] SHIFT_10 = 4'h3;
  // Control word bits; bit 15 of the word is the most significant.
  localparam int B_DONE = 15;
  localparam int B_MODE_HI = 14;
  localparam int B_MODE_LO = 13;
  localparam int B_SPECIAL = 12;
  localparam int B_LOST = 8;
  localparam int B_PAR_INH = 7;
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_ILLEGAL = 2'h1;
  localparam logic [1:0] MODE_AUTO = 2'h2;
  localparam logic [1:0] MODE_ECHO = 2'h3;
  // Start instruction data fields.
  localparam int DOC_RTC_EN = 0;
  localparam int DOC_SET_BASE = 1;
  localparam int DOC_BASE_LSB = 8;
  // Status word fields; the port number sits in the low bits.
  localparam int ST_IO = 15;
  localparam int ST_RTC = 14;
  localparam int ST_TX = 13;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  // Real time clock period.
  localparam int RTC_TIME_MS = 10;
  localparam int CLK_FREQ_KHZ = 200000;
  localparam int RTC_CYCLES = RTC_TIME_MS * CLK_FREQ_KHZ;
  // Special characters: below 40 octal or above 173 octal.
  localparam logic [6:0] SPECIAL_LO = 7'h20;
  localparam logic [6:0] SPECIAL_HI = 7'h7b;
  localparam logic [7:0] ASCII_MSB = 8'h80;
  // APB register offsets of the host end.
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_IRQ = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
endpackage

// ===== hdl/spd_scanner.sv
// Scanner end: polls ports, walks control blocks over DMA, raises interrupts.
module spd_scanner #(
  parameter int RTC_CYCLES = spd_pkg::RTC_CYCLES
) (
  input wire logic CLOCK_IN,
  input wire logic RST_N_IN,
  spd_link_if.dev LINK,
  input wire logic [spd_pkg::NPORT-1:0] RX_REQ_IN,
  input wire logic [spd_pkg::NPORT-1:0] TX_READY_IN,
  input wire logic [7:0] RX_CHAR_IN,
  input wire logic RX_PARITY_ERR_IN,
  input wire logic RX_OVERLOAD_IN,
  input wire logic RX_BREAK_IN,
  input wire logic [1:0] BLOCK_SIZE_SEL_IN,
  output logic [spd_pkg::PORT_W-1:0] PORT_OUT,
  output logic RX_TAKE_OUT,
  output logic TX_LOAD_OUT,
  output logic [7:0] TX_CHAR_OUT,
  output logic ACTIVE_OUT
);
  typedef enum logic [4:0] {
    S_IDLE, S_SCAN, S_MEM, S_RX_DECIDE, S_RX_PAR, S_RX_CLASS, S_RX_GOTPTR,
    S_RX_GOTEND, S_RX_MERGE, S_RX_ECHO, S_RX_END, S_TX_DECIDE, S_TX_GOTPTR,
    S_TX_GOTEND, S_TX_SEND, S_NEXT
  } spd_state_t;

  spd_state_t state_reg;
  spd_state_t ret_reg;
  logic [1:0] size_meta_reg;
  logic [1:0] size_sync_reg;
  logic started_reg;
  logic rtc_en_reg;
  logic [15:0] base_reg;
  logic [spd_pkg::PORT_W-1:0] port_reg;
  logic [15:0] ctl_reg;
  logic [15:0] ptr_reg;
  logic [15:0] end_reg;
  logic [15:0] word_reg;
  logic [7:0] char_reg;
  logic err_reg;
  logic dma_req_reg;
  logic dma_we_reg;
  logic [15:0] dma_addr_reg;
  logic [15:0] dma_wdata_reg;
  logic ev_reg;
  logic ev_tx_reg;
  logic pend_io_reg;
  logic pend_rtc_reg;
  logic ev_tx_last_reg;
  logic [spd_pkg::PORT_W-1:0] ev_port_reg;
  logic rtc_tick;
  logic [3:0] shift;
  logic [1:0] mode;
  logic special;
  logic [7:0] rx_char;
  logic [7:0] buf_byte;

  // Jumpers are off-chip straps, so they are synchronised before use.
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      size_meta_reg <= 2'h0;
      size_sync_reg <= 2'h0;
    end else begin
      size_meta_reg <= BLOCK_SIZE_SEL_IN;
      size_sync_reg <= size_meta_reg;
    end
  end

  always_comb begin
    case (size_sync_reg)
      spd_pkg::SIZE_SEL_20: shift = spd_pkg::SHIFT_20;
      spd_pkg::SIZE_SEL_10: shift = spd_pkg::SHIFT_10;
      default: shift = spd_pkg::SHIFT_40;
    endcase
  end

  assign mode = ctl_reg[spd_pkg::B_MODE_HI:spd_pkg::B_MODE_LO];
  assign special = (char_reg[6:0] < spd_pkg::SPECIAL_LO) || (char_reg[6:0] > spd_pkg::SPECIAL_HI);
  assign rx_char = ctl_reg[spd_pkg::B_SPECIAL] ? (char_reg | spd_pkg::ASCII_MSB) : char_reg;
  assign buf_byte = ptr_reg[0] ? word_reg[7:0] : word_reg[15:8];

  function automatic logic [15:0] cb_addr(input logic [2:0] w);
    cb_addr = base_reg + (16'(port_reg) << shift) + 16'(w);
  endfunction

  // Start instruction: arms scanning, loads the clock enable and optionally loads the base.
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      started_reg <= 1'b0;
      rtc_en_reg <= 1'b0;
      base_reg <= spd_pkg::BASE_DEFAULT;
    end else if (LINK.doc_pulse) begin
      started_reg <= 1'b1;
      rtc_en_reg <= LINK.doc_data[spd_pkg::DOC_RTC_EN];
      if (LINK.doc_data[spd_pkg::DOC_SET_BASE]) begin
        base_reg <= {LINK.doc_data[15:spd_pkg::DOC_BASE_LSB], 8'h00};
      end
    end
  end

  task automatic issue(input logic we, input logic [15:0] a, input logic [15:0] d,
                       input spd_state_t r);
    dma_req_reg <= 1'b1;
    dma_we_reg <= we;
    dma_addr_reg <= a;
    dma_wdata_reg <= d;
    ret_reg <= r;
    state_reg <= S_MEM;
  endtask

  // Sequencer: one DMA word at a time, request held until acknowledged.
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_reg <= S_IDLE;
      ret_reg <= S_IDLE;
      port_reg <= '0;
      ctl_reg <= 16'h0000;
      ptr_reg <= 16'h0000;
      end_reg <= 16'h0000;
      word_reg <= 16'h0000;
      char_reg <= 8'h00;
      err_reg <= 1'b0;
      dma_req_reg <= 1'b0;
      dma_we_reg <= 1'b0;
      dma_addr_reg <= 16'h0000;
      dma_wdata_reg <= 16'h0000;
      RX_TAKE_OUT <= 1'b0;
      TX_LOAD_OUT <= 1'b0;
      TX_CHAR_OUT <= 8'h00;
      ev_reg <= 1'b0;
      ev_tx_reg <= 1'b0;
    end else begin
      RX_TAKE_OUT <= 1'b0;
      TX_LOAD_OUT <= 1'b0;
      ev_reg <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (started_reg) begin
            state_reg <= S_SCAN;
          end
        end
        S_SCAN: begin
          if (RX_REQ_IN[port_reg]) begin
            issue(1'b0, cb_addr(spd_pkg::W_RX_CTL), 16'h0000, S_RX_DECIDE);
          end else if (TX_READY_IN[port_reg]) begin
            issue(1'b0, cb_addr(spd_pkg::W_TX_CTL), 16'h0000, S_TX_DECIDE);
          end else begin
            port_reg <= port_reg + 7'h01;
          end
        end
        S_MEM: begin
          if (LINK.dma_ack) begin
            dma_req_reg <= 1'b0;
            word_reg <= LINK.dma_rdata;
            state_reg <= ret_reg;
          end
        end
        S_RX_DECIDE: begin
          ctl_reg <= word_reg;
          char_reg <= RX_CHAR_IN;
          err_reg <= RX_OVERLOAD_IN | RX_BREAK_IN;
          if (word_reg[spd_pkg::B_DONE]) begin
            // Overrun: keep only the newest character and mark the loss, no interrupt.
            issue(1'b1, cb_addr(spd_pkg::W_RX_CTL),
                  {word_reg[15:9], 1'b1, RX_CHAR_IN}, S_RX_END);
          end else if (RX_PARITY_ERR_IN) begin
            issue(1'b0, cb_addr(spd_pkg::W_TX_CTL), 16'h0000, S_RX_PAR);
          end else begin
            state_reg <= S_RX_CLASS;
          end
        end
        S_RX_PAR: begin
          if (!word_reg[spd_pkg::B_PAR_INH]) begin
            err_reg <= 1'b1;
          end
          state_reg <= S_RX_CLASS;
        end
        S_RX_CLASS: begin
          if (err_reg || (ctl_reg[spd_pkg::B_SPECIAL] && special) ||
              mode == spd_pkg::MODE_SINGLE || mode == spd_pkg::MODE_ILLEGAL) begin
            issue(1'b1, cb_addr(spd_pkg::W_RX_CTL),
                  {1'b1, ctl_reg[14:8], rx_char}, S_RX_END);
            ev_reg <= 1'b1;
            ev_tx_reg <= 1'b0;
          end else begin
            issue(1'b0, cb_addr(spd_pkg::W_RX_PTR), 16'h0000, S_RX_GOTPTR);
          end
        end
        S_RX_GOTPTR: begin
          ptr_reg <= word_reg;
          issue(1'b0, cb_addr(spd_pkg::W_RX_END), 16'h0000, S_RX_GOTEND);
        end
        S_RX_GOTEND: begin
          end_reg <= word_reg;
          issue(1'b0, {1'b0, ptr_reg[15:1]}, 16'h0000, S_RX_MERGE);
        end
        S_RX_MERGE: begin
          // Byte 0 of a word is its high half.
          issue(1'b1, {1'b0, ptr_reg[15:1]},
                ptr_reg[0] ? {word_reg[15:8], rx_char} : {rx_char, word_reg[7:0]},
                S_RX_ECHO);
        end
        S_RX_ECHO: begin
          if (mode == spd_pkg::MODE_ECHO && TX_READY_IN[port_reg]) begin
            TX_LOAD_OUT <= 1'b1;
            TX_CHAR_OUT <= rx_char;
          end
          if (ptr_reg == end_reg || (mode == spd_pkg::MODE_ECHO && !TX_READY_IN[port_reg])) begin
            issue(1'b1, cb_addr(spd_pkg::W_RX_CTL),
                  {1'b1, ctl_reg[14:8], rx_char}, S_RX_END);
            ev_reg <= 1'b1;
            ev_tx_reg <= 1'b0;
          end else begin
            issue(1'b1, cb_addr(spd_pkg::W_RX_PTR), 16'(ptr_reg + 16'h0001), S_RX_END);
          end
        end
        S_RX_END: begin
          RX_TAKE_OUT <= 1'b1;
          port_reg <= port_reg + 7'h01;
          state_reg <= S_SCAN;
        end
        S_TX_DECIDE: begin
          ctl_reg <= word_reg;
          if (word_reg[spd_pkg::B_DONE]) begin
            state_reg <= S_NEXT;
          end else if (word_reg[spd_pkg::B_MODE_HI] == 1'b0) begin
            TX_LOAD_OUT <= 1'b1;
            TX_CHAR_OUT <= word_reg[7:0];
            issue(1'b1, cb_addr(spd_pkg::W_TX_CTL), {1'b1, word_reg[14:0]}, S_NEXT);
            ev_reg <= 1'b1;
            ev_tx_reg <= 1'b1;
          end else begin
            issue(1'b0, cb_addr(spd_pkg::W_TX_PTR), 16'h0000, S_TX_GOTPTR);
          end
        end
        S_TX_GOTPTR: begin
          ptr_reg <= word_reg;
          issue(1'b0, cb_addr(spd_pkg::W_TX_END), 16'h0000, S_TX_GOTEND);
        end
        S_TX_GOTEND: begin
          end_reg <= word_reg;
          issue(1'b0, {1'b0, ptr_reg[15:1]}, 16'h0000, S_TX_SEND);
        end
        S_TX_SEND: begin
          TX_LOAD_OUT <= 1'b1;
          TX_CHAR_OUT <= buf_byte;
          if (ptr_reg == end_reg) begin
            issue(1'b1, cb_addr(spd_pkg::W_TX_CTL), {1'b1, ctl_reg[14:0]}, S_NEXT);
            ev_reg <= 1'b1;
            ev_tx_reg <= 1'b1;
          end else begin
            issue(1'b1, cb_addr(spd_pkg::W_TX_PTR), 16'(ptr_reg + 16'h0001), S_NEXT);
          end
        end
        S_NEXT: begin
          port_reg <= port_reg + 7'h01;
          state_reg <= S_SCAN;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  spd_tick_div #(
    .CYCLES(RTC_CYCLES)
  ) u_rtc (
    .clk_in(CLOCK_IN),
    .rst_n_in(RST_N_IN),
    .en_in(rtc_en_reg),
    .tick_out(rtc_tick)
  );

  // Pending interrupt causes; a new event in the clearing cycle survives.
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      pend_io_reg <= 1'b0;
      pend_rtc_reg <= 1'b0;
      ev_tx_last_reg <= 1'b0;
      ev_port_reg <= '0;
    end else begin
      pend_io_reg <= ev_reg | (pend_io_reg & ~LINK.status_read_clear_instruction_pulse);
      pend_rtc_reg <= rtc_tick | (pend_rtc_reg & ~LINK.status_read_clear_instruction_pulse);
      if (ev_reg) begin
        ev_tx_last_reg <= ev_tx_reg;
        ev_port_reg <= port_reg;
      end
    end
  end

  assign LINK.status_word = {pend_io_reg, pend_rtc_reg, ev_tx_last_reg, 6'h00, ev_port_reg};
  assign LINK.irq = pend_io_reg | pend_rtc_reg;
  assign LINK.dma_req = dma_req_reg;
  assign LINK.dma_we = dma_we_reg;
  assign LINK.dma_addr = dma_addr_reg;
  assign LINK.dma_wdata = dma_wdata_reg;
  assign PORT_OUT = port_reg;
  assign ACTIVE_OUT = started_reg;
endmodule

// ===== hdl/spd_tick_div.sv
// Divider giving a one-cycle tick every CYCLES clocks while enabled.
module spd_tick_div #(
  parameter int CYCLES = 2000000
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic en_in,
  output logic tick_out
);
  logic [31:0] cnt_reg;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_reg <= 32'h0000_0000;
      tick_out <= 1'b0;
    end else if (!en_in) begin
      cnt_reg <= 32'h0000_0000;
      tick_out <= 1'b0;
    end else if (cnt_reg == 32'(CYCLES - 1)) begin
      cnt_reg <= 32'h0000_0000;
      tick_out <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 32'h0000_0001;
      tick_out <= 1'b0;
    end
  end
endmodule

// ===== tb/spd_asserts.sv
// Concurrent checks on the link between the scanner and the host end.
module spd_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic doc_pulse,
  input wire logic [15:0] doc_data,
  input wire logic status_read_clear_instruction_pulse,
  input wire logic [15:0] status_word,
  input wire logic irq,
  input wire logic dma_req,
  input wire logic dma_we,
  input wire logic [15:0] dma_addr,
  input wire logic [15:0] dma_wdata,
  input wire logic dma_ack,
  input wire logic [15:0] dma_rdata
);
  logic started_reg;
  logic rtc_en_reg;
  logic [3:0] since_wr_reg;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      started_reg <= 1'b0;
      rtc_en_reg <= 1'b0;
    end else if (doc_pulse) begin
      started_reg <= 1'b1;
      rtc_en_reg <= doc_data[0];
    end
  end
  // Saturates so that a long quiet spell never wraps back into the window.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      since_wr_reg <= 4'hf;
    end else if (dma_req && dma_we) begin
      since_wr_reg <= 4'h0;
    end else if (since_wr_reg != 4'hf) begin
      since_wr_reg <= since_wr_reg + 4'h1;
    end
  end
  dma_hold_a: assert property (dma_req && !dma_ack |=> dma_req && $stable(dma_addr)
    && $stable(dma_we) && $stable(dma_wdata)) else $error("dma request changed before ack");
  dma_drop_a: assert property (dma_req && dma_ack |=> !dma_req)
    else $error("dma request not dropped after ack");
  idle_start_a: assert property (!started_reg && !doc_pulse |-> !dma_req)
    else $error("dma before start instruction");
  irq_pend_a: assert property (irq == (status_word[15] | status_word[14]))
    else $error("irq differs from pending bits");
  clear_io_a: assert property (status_read_clear_instruction_pulse && !dma_req && !dma_ack |=> !status_word[15])
    else $error("status read did not clear io pending");
  done_wr_a: assert property ($rose(status_word[15]) |-> since_wr_reg <= 4'h4)
    else $error("io pending without control word write");
  pulse_one_a: assert property (doc_pulse || status_read_clear_instruction_pulse |=> !doc_pulse && !status_read_clear_instruction_pulse)
    else $error("instruction pulse longer than one cycle");
  rtc_gate_a: assert property ($rose(status_word[14]) |-> rtc_en_reg || $past(rtc_en_reg, 2))
    else $error("clock interrupt while clock disabled");
endmodule

// ===== tb/tb_serial_port_dma_scanner.sv
// Self-checking bench joining scanner and host end, with a memory model.
module tb_serial_port_dma_scanner;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int RTC_N = 50;
  localparam logic [15:0] W0 [7] = '{16'h4000, 16'h4000, 16'h4000, 16'h4000, 16'h6000,
    16'h5000, 16'h4000};
  localparam logic [2:0] ER [7] = '{3'h4, 3'h2, 3'h1, 3'h4, 3'h0, 3'h0, 3'h0};
  localparam logic [6:0] DN = 7'h37;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, mack = 1'b0;
  logic [7:0] pa = 8'h00, ch = 8'h00, tch;
  logic [31:0] pwd = 32'h0000_0000, prd;
  logic prdy, pslv, irq, mreq, mwe, tl, rt, act;
  logic [15:0] madr, mwd, mrd = 16'h0000, base = 16'h3c00;
  logic [127:0] rxq = '0, txr = '0;
  logic [2:0] er = 3'h0;
  logic [1:0] bs = 2'h0;
  logic [6:0] port;
  logic [15:0] mem [0:65535];
  int sh = 5, fail_count = 0, cmp_count = 0, bad = 0;
  bit single = 1'b0;
  always #2.5 clk = ~clk;
  spd_link_if link (.clk(clk), .rst_n(rst_n));
  spd_scanner #(.RTC_CYCLES(RTC_N)) i_spd_scanner (.CLOCK_IN(clk), .RST_N_IN(rst_n), .LINK(link),
    .RX_REQ_IN(rxq), .TX_READY_IN(txr), .RX_CHAR_IN(ch), .RX_PARITY_ERR_IN(er[2]),
    .RX_OVERLOAD_IN(er[1]), .RX_BREAK_IN(er[0]), .BLOCK_SIZE_SEL_IN(bs), .PORT_OUT(port),
    .RX_TAKE_OUT(rt), .TX_LOAD_OUT(tl), .TX_CHAR_OUT(tch), .ACTIVE_OUT(act));
  spd_host_end i_spd_host_end (.CLOCK_IN(clk), .RST_N_IN(rst_n), .LINK(link), .PSEL_IN(psel),
    .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(pa), .PWDATA_IN(pwd), .PRDATA_OUT(prd),
    .PREADY_OUT(prdy), .PSLVERR_OUT(pslv), .IRQ_OUT(irq), .MEM_REQ_OUT(mreq), .MEM_WE_OUT(mwe),
    .MEM_ADDR_OUT(madr), .MEM_WDATA_OUT(mwd), .MEM_ACK_IN(mack), .MEM_RDATA_IN(mrd));
  spd_asserts i_spd_asserts (.clk(clk), .rst_n(rst_n), .doc_pulse(link.doc_pulse),
    .doc_data(link.doc_data), .status_read_clear_instruction_pulse(link.status_read_clear_instruction_pulse), .status_word(link.status_word),
    .irq(link.irq), .dma_req(link.dma_req), .dma_we(link.dma_we), .dma_addr(link.dma_addr),
    .dma_wdata(link.dma_wdata), .dma_ack(link.dma_ack), .dma_rdata(link.dma_rdata));
  function automatic logic [15:0] port_control_block(int p, int w);
    return base + 16'(p << sh) + 16'(w);
  endfunction
  // Only control and pointer words may be touched inside the block area; pointers never in single mode.
  function automatic bit ok(logic [15:0] a);
    int o;
    o = int'(a) - int'(base);
    if (o < 0 || o >= (128 << sh)) return 1'b1;
    o = o & ((1 << sh) - 1);
    return (o < 2 || (o >= 4 && o < 8)) && !(single && o >= 4);
  endfunction
  // Random ack latency; released data lines toggle so stale values never pass.
  always @(posedge clk) begin
    if (mreq && !mack && $urandom_range(2) == 0) begin
      mack <= 1'b1;
      mrd <= mem[madr];
      if (mwe) mem[madr] <= mwd;
      if (!ok(madr)) bad++;
    end else begin
      mack <= 1'b0;
      mrd <= ~mrd;
    end
  end
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'b1 && n < 50);
    q = prd;
    psel <= 1'b0;
    pen <= 1'b0;
    if (n >= 50) chk(32'h0000_0000, 32'h0000_0001);
  endtask
  task automatic wt(input bit tx);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((tx ? tl : rt) !== 1'b1 && n < 4000);
    if (n >= 4000) chk(32'h0000_0000, 32'h0000_0001);
  endtask
  task automatic rx(input int p, input logic [7:0] c, input logic [2:0] e);
    @(posedge clk);
    rxq[p] <= 1'b1;
    ch <= c;
    er <= e;
    wt(1'b0);
    rxq[p] <= 1'b0;
    er <= 3'h0;
    repeat (4) @(posedge clk);
  endtask
  task automatic st(output logic [31:0] q);
    apb(1'b0, spd_pkg::REG_STATUS, 32'h0000_0000, q);
    repeat (3) @(posedge clk);
  endtask
  task automatic wirq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk(irq, 1'b1);
  endtask
  initial begin
    #400000;
    fail_count++;
    wrap_up();
  end
  initial begin
    logic [31:0] q;
    int p, k;
    logic [7:0] c;
    longint t0;
    for (k = 0; k < 65536; k++) mem[k] = 16'h0000;
    void'($urandom(50112));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rxq[5] <= 1'b1;
    repeat (200) @(posedge clk);
    chk({act, mreq, irq}, 3'h0);
    rxq[5] <= 1'b0;
    apb(1'b0, 8'h0c, 32'h0000_0000, q);
    chk(pslv, 1'b1);
    single = 1'b1;
    apb(1'b1, spd_pkg::REG_CMD, 32'h0000_0000, q);
    repeat (2) @(posedge clk);
    chk(act, 1'b1);
    for (k = 0; k < 3; k++) begin
      bs <= k[1:0];
      sh = 5 - k;
      p = $urandom_range(127);
      c = 8'($urandom_range(255));
      mem[port_control_block(p, 0)] = 16'h0000;
      repeat (4) @(posedge clk);
      rx(p, c, 3'h0);
      chk(mem[port_control_block(p, 0)], {8'h80, c});
      chk(irq, 1'b1);
      st(q);
      chk(q[15:0], {9'h100, 7'(p)});
      chk(irq, 1'b0);
    end
    k = $urandom_range(48, 8);
    base = {k[7:0], 8'h00};
    apb(1'b1, spd_pkg::REG_CMD, {16'h0000, k[7:0], 8'h02}, q);
    p = $urandom_range(127);
    mem[port_control_block(p, 0)] = 16'h0000;
    rx(p, 8'h11, 3'h0);
    chk(mem[port_control_block(p, 0)], 16'h8011);
    st(q);
    rx(p, 8'h22, 3'h0);
    chk(mem[port_control_block(p, 0)], 16'h8122);
    chk(irq, 1'b0);
    single = 1'b0;
    for (k = 0; k < 7; k++) begin
      p = $urandom_range(127);
      c = (k == 5) ? 8'h0d : 8'h30 + 8'($urandom_range(74));
      mem[port_control_block(p, 0)] = W0[k];
      mem[port_control_block(p, 1)] = (k == 3) ? 16'h0080 : 16'h0000;
      mem[port_control_block(p, 4)] = 16'he000;
      mem[port_control_block(p, 6)] = 16'he001;
      rx(p, c, ER[k]);
      chk(mem[port_control_block(p, 0)][15], DN[k]);
      chk(irq, DN[k]);
      if (k == 6) begin
        rx(p, 8'h5a, 3'h0);
        chk(mem[16'h7000], {c, 8'h5a});
        chk(mem[port_control_block(p, 0)][15], 1'b1);
      end
      st(q);
    end
    // Echo with a ready transmitter: the character goes out and the buffer is not yet full.
    p = $urandom_range(127);
    mem[port_control_block(p, 0)] = 16'h6000;
    mem[port_control_block(p, 1)] = 16'h8000;
    mem[port_control_block(p, 4)] = 16'he000;
    mem[port_control_block(p, 6)] = 16'he003;
    txr[p] <= 1'b1;
    rx(p, 8'h41, 3'h0);
    txr[p] <= 1'b0;
    chk(tch, 8'h41);
    chk(mem[port_control_block(p, 0)][15], 1'b0);
    single = 1'b1;
    p = $urandom_range(127);
    c = 8'($urandom_range(255));
    mem[port_control_block(p, 0)] = 16'h0000;
    mem[port_control_block(p, 1)] = {8'h00, c};
    @(posedge clk);
    rxq[p] <= 1'b1;
    txr[p] <= 1'b1;
    ch <= 8'h33;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (rt !== 1'b1 && tl !== 1'b1 && k < 4000);
    chk({rt, tl}, 2'h2);
    rxq[p] <= 1'b0;
    wt(1'b1);
    chk(tch, c);
    txr[p] <= 1'b0;
    repeat (6) @(posedge clk);
    chk(mem[port_control_block(p, 1)], {8'h80, c});
    st(q);
    chk(q[15:0], {9'h140, 7'(p)});
    apb(1'b1, spd_pkg::REG_CMD, 32'h0000_0001, q);
    wirq();
    t0 = $time;
    st(q);
    chk(q[14], 1'b1);
    wirq();
    chk(32'(($time - t0) / 5), RTC_N);
    apb(1'b1, spd_pkg::REG_CMD, 32'h0000_0000, q);
    st(q);
    chk(bad, 0);
    wrap_up();
  end
endmodule
